// file: design/prei_top.sv
// Purpose: chooses and holds the outbound REI-P field of the path status byte
// Assumes: APB slave, zero wait states; receive parity result from same clock
// Notes:   reiField feeds G1 bits 1..4 of each outbound SPE
//
// Contract
// - source select 00 takes REI-P from paired receive parity results
// - automatic value goes into G1 bits 1 to 4 of every SPE
// - receive control bit 0 picks bit count or errored-SPE flag
// - style 0 sends the errored parity bit count, 0 to 8
// - style 1 sends 1 if last SPE had a parity error, else 0
// - source select 01 copies status value bits 7 to 4 into G1
// - source select 10 takes REI-P serially from the overhead input pin
// - device drives port clock, enable, frame; far end samples on falling edges
// - device captures each bit at the following rising port clock edge
`timescale 1ns/10ps
module prei_top
	import prei_pkg::*;
#(
	parameter int DIV   = PORT_DIV,
	parameter int WAITN = PORT_WAIT_CLKS
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// receive path parity result
	input  wire logic [3:0]  parityErrBits,
	input  wire logic        parityDone,
	// outbound spe timing and insertion
	input  wire logic        speStart,
	output logic      [3:0]  reiField,
	// serial overhead port
	input  wire logic        overheadSerialIn,
	output logic             overheadPortClockOut,
	output logic             overheadPortEnableOut,
	output logic             overheadPortFrameOut
);

	function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
		hit = (a[1:0] == 2'b00) && (a[17:2] == idx);
	endfunction

	prei_port_if port ();

	prei_port_engine #(
		.DIV   (DIV),
		.WAITN (WAITN)
	) u_engine (
		.ref_clk               (ref_clk),
		.rst_n                 (rst_n),
		.overheadSerialIn      (overheadSerialIn),
		.overheadPortClockOut  (overheadPortClockOut),
		.overheadPortEnableOut (overheadPortEnableOut),
		.overheadPortFrameOut  (overheadPortFrameOut),
		.port                  (port)
	);

	logic [7:0]  rxCtl_reg, rxCtl_next;
	logic [7:0]  txCtl_reg, txCtl_next;
	logic [7:0]  stVal_reg, stVal_next;
	logic [3:0]  autoRei_reg, autoRei_next;
	logic [3:0]  extRei_reg, extRei_next;
	logic [3:0]  rei_reg, rei_next;
	logic [3:0]  pending_reg, pending_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        err_reg, err_next;
	logic        wrEn;
	logic        setup;
	logic        mapped;
	prei_src_t   src;

	always_comb begin
		src          = prei_src_t'(txCtl_reg[REI_SEL_MSB:REI_SEL_LSB]);
		setup        = psel && !penable;
		wrEn         = psel && penable && pwrite;
		mapped       = hit(paddr, RX_PATH_CONTROL_0_IDX) || hit(paddr, TX_PATH_CONTROL_0_IDX)
			|| hit(paddr, TX_PATH_STATUS_BYTE_VALUE_IDX) || hit(paddr, REI_STATUS_IDX);
		rxCtl_next   = rxCtl_reg;
		txCtl_next   = txCtl_reg;
		stVal_next   = stVal_reg;
		rdata_next   = rdata_reg;
		err_next     = err_reg;
		if (setup) begin
			err_next   = !mapped;
			rdata_next = 32'h0000_0000;
			if (hit(paddr, RX_PATH_CONTROL_0_IDX))
				rdata_next[7:0] = rxCtl_reg;
			if (hit(paddr, TX_PATH_CONTROL_0_IDX))
				rdata_next[7:0] = txCtl_reg;
			if (hit(paddr, TX_PATH_STATUS_BYTE_VALUE_IDX))
				rdata_next[7:0] = stVal_reg;
			if (hit(paddr, REI_STATUS_IDX))
				rdata_next[7:0] = {extRei_reg, rei_reg};
		end
		if (wrEn) begin
			// style bit and its neighbours writable, upper bits read zero
			if (hit(paddr, RX_PATH_CONTROL_0_IDX))
				rxCtl_next = {4'h0, pwdata[RX_WRITABLE_MSB:0]};
			if (hit(paddr, TX_PATH_CONTROL_0_IDX))
				txCtl_next = pwdata[7:0];
			// value written by software, 0 no error, 1..8 count
			if (hit(paddr, TX_PATH_STATUS_BYTE_VALUE_IDX))
				stVal_next = pwdata[7:0];
		end
	end

	always_comb begin
		autoRei_next = autoRei_reg;
		extRei_next  = extRei_reg;
		if (parityDone) begin
			// count of errored bits or a single errored-SPE flag
			if (rxCtl_reg[PARITY_STYLE_BIT])
				autoRei_next = (parityErrBits != 4'h0) ? 4'h1 : 4'h0;
			else
				autoRei_next = parityErrBits;
		end
		if (port.nibbleDone)
			extRei_next = port.nibble;
		case (src)
			PREI_SRC_SOFT: pending_next = stVal_reg[SW_REI_MSB:SW_REI_LSB];
			PREI_SRC_EXT:  pending_next = extRei_next;
			default:       pending_next = autoRei_next;
		endcase
		// value loaded at the start of every outbound SPE
		rei_next = speStart ? pending_reg : rei_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxCtl_reg   <= RX_PATH_CONTROL_0_RST;
			txCtl_reg   <= TX_PATH_CONTROL_0_RST;
			stVal_reg   <= TX_PATH_STATUS_BYTE_VALUE_RST;
			autoRei_reg <= 4'h0;
			extRei_reg  <= 4'h0;
			pending_reg <= 4'h0;
			rei_reg     <= 4'h0;
			rdata_reg   <= 32'h0000_0000;
			err_reg     <= 1'b0;
		end else begin
			rxCtl_reg   <= rxCtl_next;
			txCtl_reg   <= txCtl_next;
			stVal_reg   <= stVal_next;
			autoRei_reg <= autoRei_next;
			extRei_reg  <= extRei_next;
			pending_reg <= pending_next;
			rei_reg     <= rei_next;
			rdata_reg   <= rdata_next;
			err_reg     <= err_next;
		end
	end

	assign port.frameStart = speStart;
	assign reiField        = rei_reg;
	assign prdata          = rdata_reg;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && err_reg;

endmodule

// file: design/prei_pkg.sv
// Purpose: shared constants for the path remote error insertion block
// Assumes: 50 MHz ref_clk, APB with 32-bit data
// Notes:   register byte address is four times the register index
package prei_pkg;

	// timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int PORT_PERIOD_NS  = 160;
	localparam int PORT_DIV        = PORT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PORT_WAIT_CLKS  = 28;
	localparam int REI_BITS        = 4;

	// register indices, byte address = index * 4
	localparam logic [15:0] RX_PATH_CONTROL_0_IDX         = 16'h1183;
	localparam logic [15:0] TX_PATH_CONTROL_0_IDX         = 16'h1983;
	localparam logic [15:0] TX_PATH_STATUS_BYTE_VALUE_IDX = 16'h199f;
	localparam logic [15:0] REI_STATUS_IDX                = 16'h19a0;

	// reset values
	localparam logic [7:0] RX_PATH_CONTROL_0_RST         = 8'h00;
	localparam logic [7:0] TX_PATH_CONTROL_0_RST         = 8'h00;
	localparam logic [7:0] TX_PATH_STATUS_BYTE_VALUE_RST = 8'h00;

	// field positions
	localparam int RX_WRITABLE_MSB     = 3;
	localparam int PARITY_STYLE_BIT    = 0;
	localparam int REI_SEL_LSB         = 5;
	localparam int REI_SEL_MSB         = 6;
	localparam int SW_REI_LSB          = 4;
	localparam int SW_REI_MSB          = 7;
	localparam int STATUS_EXT_LSB      = 4;

	typedef enum logic [1:0] {
		PREI_SRC_AUTO = 2'b00,
		PREI_SRC_SOFT = 2'b01,
		PREI_SRC_EXT  = 2'b10,
		PREI_SRC_RSVD = 2'b11
	} prei_src_t;

	typedef enum logic [1:0] {
		PREI_PORT_IDLE  = 2'b00,
		PREI_PORT_WAIT  = 2'b01,
		PREI_PORT_SHIFT = 2'b10
	} prei_port_state_t;

endpackage

// file: design/prei_port_if.sv
// Purpose: carries frame start and captured nibble between top and port engine
// Assumes: single ref_clk domain
// Notes:   nibbleDone is a one-cycle pulse
`timescale 1ns/10ps
interface prei_port_if;
	logic       frameStart;
	logic [3:0] nibble;
	logic       nibbleDone;

	modport ctrl (
		output frameStart,
		input  nibble,
		input  nibbleDone
	);
	modport engine (
		input  frameStart,
		output nibble,
		output nibbleDone
	);
endinterface

// file: design/prei_port_engine.sv
// Purpose: serial overhead port, makes the port clock and frame marks, shifts in bits
// Assumes: port clock is ref_clk divided by PORT_DIV
// Notes:   input pin passes two flip-flops before use
`timescale 1ns/10ps
module prei_port_engine
	import prei_pkg::*;
#(
	parameter int DIV   = PORT_DIV,
	parameter int WAITN = PORT_WAIT_CLKS
) (
	// clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst_n,
	// serial port pins
	input  wire logic   overheadSerialIn,
	output logic        overheadPortClockOut,
	output logic        overheadPortEnableOut,
	output logic        overheadPortFrameOut,
	// link to top
	prei_port_if.engine port
);

	if (DIV < 4 || DIV % 2 != 0 || DIV > 255 || WAITN < 1 || WAITN > 60) begin : g_bad_cfg
		$error("prei_port_engine: unsupported DIV or WAITN");
	end

	localparam logic [7:0] DIV_LAST   = 8'(DIV - 1);
	localparam logic [7:0] DIV_HALF   = 8'(DIV / 2);
	localparam logic [7:0] SAMPLE_CNT = 8'd2;
	// far end counts from the edge after frame rose, so bits land one period later
	localparam logic [5:0] WAIT_LAST  = 6'(WAITN + 1);
	localparam logic [2:0] BIT_LAST   = 3'(REI_BITS - 1);

	logic             syncA_reg, syncB_reg;
	logic [7:0]       divCnt_reg, divCnt_next;
	logic             pend_reg, pend_next;
	logic             en_reg, en_next;
	logic             frm_reg, frm_next;
	logic             clk_reg, clk_next;
	logic [5:0]       per_reg, per_next;
	logic [2:0]       bit_reg, bit_next;
	logic [3:0]       sh_reg, sh_next;
	logic             done_reg, done_next;
	prei_port_state_t st_reg, st_next;
	logic             rise;
	logic             samp;

	always_comb begin
		divCnt_next = (divCnt_reg == DIV_LAST) ? 8'h00 : divCnt_reg + 8'h01;
		rise        = (divCnt_reg == DIV_LAST);
		samp        = (divCnt_reg == SAMPLE_CNT);
		clk_next    = (divCnt_next < DIV_HALF);
		pend_next   = pend_reg | port.frameStart;
		en_next     = en_reg;
		frm_next    = frm_reg;
		per_next    = per_reg;
		bit_next    = bit_reg;
		sh_next     = sh_reg;
		done_next   = 1'b0;
		st_next     = st_reg;
		case (st_reg)
			PREI_PORT_IDLE: begin
				if (rise && pend_reg) begin
					// enable and frame high together for one port period
					en_next   = 1'b1;
					frm_next  = 1'b1;
					pend_next = port.frameStart;
					per_next  = 6'h00;
					st_next   = PREI_PORT_WAIT;
				end
			end
			PREI_PORT_WAIT: begin
				if (rise) begin
					frm_next = 1'b0;
					per_next = per_reg + 6'h01;
					// far end waits out its periods, first bit comes after
					if (per_reg == WAIT_LAST) begin
						bit_next = 3'h0;
						st_next  = PREI_PORT_SHIFT;
					end
				end
			end
			PREI_PORT_SHIFT: begin
				// bit sampled as it stood at the port rising edge
				if (samp) begin
					sh_next  = {sh_reg[2:0], syncB_reg};
					bit_next = bit_reg + 3'h1;
					if (bit_reg == BIT_LAST) begin
						en_next   = 1'b0;
						done_next = 1'b1;
						st_next   = PREI_PORT_IDLE;
					end
				end
			end
			default: st_next = PREI_PORT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_reg  <= 1'b0;
			syncB_reg  <= 1'b0;
			// start at the last count so the first high phase is full length
			divCnt_reg <= DIV_LAST;
			pend_reg   <= 1'b0;
			en_reg     <= 1'b0;
			frm_reg    <= 1'b0;
			clk_reg    <= 1'b0;
			per_reg    <= 6'h00;
			bit_reg    <= 3'h0;
			sh_reg     <= 4'h0;
			done_reg   <= 1'b0;
			st_reg     <= PREI_PORT_IDLE;
		end else begin
			syncA_reg  <= overheadSerialIn;
			syncB_reg  <= syncA_reg;
			divCnt_reg <= divCnt_next;
			pend_reg   <= pend_next;
			en_reg     <= en_next;
			frm_reg    <= frm_next;
			clk_reg    <= clk_next;
			per_reg    <= per_next;
			bit_reg    <= bit_next;
			sh_reg     <= sh_next;
			done_reg   <= done_next;
			st_reg     <= st_next;
		end
	end

	// port clock and marks driven by the device
	assign overheadPortClockOut  = clk_reg;
	assign overheadPortEnableOut = en_reg;
	assign overheadPortFrameOut  = frm_reg;
	assign port.nibble           = sh_reg;
	assign port.nibbleDone       = done_reg;

endmodule

// file: bench/prei_top_props.sv
// Purpose: port checks for prei_top
// Assumes: config writes seen on apb
// Notes:   style and select tracked here
`timescale 1ns/10ps
module prei_checker
	import prei_pkg::*;
#(
	parameter int DIV   = PORT_DIV,
	parameter int WAITN = PORT_WAIT_CLKS
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// path
	input wire logic [3:0]  parityErrBits,
	input wire logic        parityDone,
	input wire logic        speStart,
	input wire logic [3:0]  reiField,
	// port
	input wire logic        overheadSerialIn,
	input wire logic        overheadPortClockOut,
	input wire logic        overheadPortEnableOut,
	input wire logic        overheadPortFrameOut
);
	localparam int HALF  = DIV / 2;
	localparam int ENLEN = (WAITN + 5) * DIV + 3;
	logic [1:0] selReg;
	logic [1:0] selNext;
	logic       styleReg;
	logic       styleNext;
	logic       wrEn;
	assign wrEn = psel && penable && pwrite;
	always_comb begin
		selNext = selReg;
		styleNext = styleReg;
		if (wrEn && paddr == {TX_PATH_CONTROL_0_IDX, 2'b00})
			selNext = pwdata[REI_SEL_MSB:REI_SEL_LSB];
		if (wrEn && paddr == {RX_PATH_CONTROL_0_IDX, 2'b00})
			styleNext = pwdata[PARITY_STYLE_BIT];
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			selReg <= 2'b00;
			styleReg <= 1'b0;
		end else begin
			selReg <= selNext;
			styleReg <= styleNext;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_auto(logic st);
		parityDone && !speStart && selReg[1] == selReg[0] && styleReg == st
		##1 !parityDone && !speStart ##1 !parityDone && speStart;
	endsequence
	property p_count; s_auto(1'b0) |=> reiField == $past(parityErrBits, 3); endproperty
	property p_flag;
		s_auto(1'b1) |=> reiField == {3'b000, $past(parityErrBits, 3) != 4'h0};
	endproperty
	property p_hold; !speStart |=> $stable(reiField); endproperty
	property p_pclk; $rose(overheadPortClockOut) |-> ##HALF $fell(overheadPortClockOut); endproperty
	property p_frame;
		$rose(overheadPortFrameOut) |-> $rose(overheadPortClockOut) && overheadPortEnableOut
		##1 overheadPortFrameOut[*7] ##1 !overheadPortFrameOut;
	endproperty
	property p_enlen; $rose(overheadPortEnableOut) |-> ##ENLEN $fell(overheadPortEnableOut); endproperty
	property p_ready; psel && penable |-> pready; endproperty
	property p_align; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
	property p_rdhi; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_count: assert property (p_count) else $error("count value wrong");
	a_flag: assert property (p_flag) else $error("flag value wrong");
	a_hold: assert property (p_hold) else $error("field moved mid spe");
	a_pclk: assert property (p_pclk) else $error("port clock rate wrong");
	a_frame: assert property (p_frame) else $error("frame mark wrong");
	a_enlen: assert property (p_enlen) else $error("enable span wrong");
	a_ready: assert property (p_ready) else $error("pready low");
	a_align: assert property (p_align) else $error("unaligned not refused");
	a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
endmodule
bind prei_top prei_checker #(.DIV(DIV), .WAITN(WAITN)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .parityErrBits(parityErrBits),
	.parityDone(parityDone), .speStart(speStart), .reiField(reiField),
	.overheadSerialIn(overheadSerialIn), .overheadPortClockOut(overheadPortClockOut),
	.overheadPortEnableOut(overheadPortEnableOut),
	.overheadPortFrameOut(overheadPortFrameOut)
);

// file: bench/prei_far_end.sv
// Purpose: far end logic feeding the serial pin
// Assumes: port clock made by the block
// Notes:   idle pin shows inverse of last bit
`timescale 1ns/10ps
module prei_far_end
	import prei_pkg::*;
#(
	parameter int WAITN = PORT_WAIT_CLKS
) (
	// port pins
	input  wire logic       portClk,
	input  wire logic       portEn,
	input  wire logic       portFrame,
	output logic            serialOut,
	// value to send
	input  wire logic [3:0] nibble
);
	initial serialOut = 1'b0;
	always begin
		@(negedge portClk);
		if (portEn && portFrame) begin
			@(posedge portClk);
			repeat (WAITN) @(posedge portClk);
			for (int i = 3; i >= 0; i--) begin
				@(negedge portClk);
				serialOut = nibble[i];
			end
			@(negedge portClk);
			serialOut = ~serialOut;
		end
	end
endmodule

// file: bench/tb_prei_top.sv
// Purpose: self-checking bench for prei_top
// Assumes: default DIV and WAITN
// Notes:   far end model feeds the serial pin
`timescale 1ns/10ps
module tb_prei_top import prei_pkg::*;;
	localparam logic [17:0] RXA = {RX_PATH_CONTROL_0_IDX, 2'b00};
	localparam logic [17:0] TXA = {TX_PATH_CONTROL_0_IDX, 2'b00};
	localparam logic [17:0] SVA = {TX_PATH_STATUS_BYTE_VALUE_IDX, 2'b00};
	localparam logic [17:0] STA = {REI_STATUS_IDX, 2'b00};
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  parityErrBits = 4'h0;
	logic        parityDone = 1'b0;
	logic        speStart = 1'b0;
	logic [3:0]  reiField;
	logic        serIn;
	logic        pClk;
	logic        pEn;
	logic        pFr;
	logic [3:0]  farNib = 4'h0;
	int          fails = 0;
	int          samplesChecked = 0;
	always #10 ref_clk = ~ref_clk;
	prei_top dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .parityErrBits(parityErrBits),
		.parityDone(parityDone), .speStart(speStart), .reiField(reiField),
		.overheadSerialIn(serIn), .overheadPortClockOut(pClk),
		.overheadPortEnableOut(pEn), .overheadPortFrameOut(pFr)
	);
	prei_far_end far_u (.portClk(pClk), .portEn(pEn), .portFrame(pFr),
		.serialOut(serIn), .nibble(farNib));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samplesChecked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		if (fails == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask
	task automatic rdchk(input string n, input logic [17:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 8'h00, r, e);
		chk(n, r, x);
	endtask
	task automatic spe;
		@(posedge ref_clk);
		speStart <= 1'b1;
		@(posedge ref_clk);
		speStart <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic auto_val(input logic [3:0] v, input logic [3:0] x);
		@(posedge ref_clk);
		parityDone <= 1'b1;
		parityErrBits <= v;
		@(posedge ref_clk);
		parityDone <= 1'b0;
		spe();
		chk("reiField", reiField, x);
	endtask
	task automatic wait_en(input logic l);
		int n;
		n = 0;
		while (pEn !== l && n < 600) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 600) fails++;
	endtask
	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rdchk("rxCtrl", RXA, RX_PATH_CONTROL_0_RST);
		rdchk("txCtrl", TXA, TX_PATH_CONTROL_0_RST);
		rdchk("swValue", SVA, TX_PATH_STATUS_BYTE_VALUE_RST);
		wr(RXA, 8'hff);
		rdchk("rxCtrl", RXA, 32'h0f);
		wr(RXA, 8'h00);
		apb(18'h00004, 1'b0, 8'h00, r, e);
		chk("unmappedErr", e, 32'h1);
		chk("unmappedData", r, 32'h0);
		apb(TXA + 18'h1, 1'b1, 8'h40, r, e);
		chk("unalignedErr", e, 32'h1);
		rdchk("txCtrl", TXA, 32'h0);
	endtask
	task automatic t_auto;
		for (int v = 0; v <= 8; v++) auto_val(v[3:0], v[3:0]);
		wr(RXA, 8'h01);
		auto_val(4'h0, 4'h0);
		auto_val(4'h6, 4'h1);
		wr(TXA, 8'h60);
		auto_val(4'h8, 4'h1);
		wr(RXA, 8'h00);
	endtask
	task automatic t_soft;
		wr(TXA, 8'h20);
		for (int v = 0; v <= 8; v++) begin
			wr(SVA, {v[3:0], 4'h0});
			auto_val(4'h3, v[3:0]);
		end
	endtask
	task automatic t_ext(input logic [3:0] n);
		farNib <= n;
		wait_en(1'b0);
		spe();
		wait_en(1'b1);
		wait_en(1'b0);
		spe();
		chk("reiField", reiField, n);
		rdchk("status", STA, {24'h0, n, n});
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_auto();
		t_soft();
		wr(TXA, 8'h40);
		t_ext(4'hb);
		t_ext(4'h4);
		stop_test();
	end
	initial begin
		#(20 * 20000);
		fails++;
		stop_test();
	end
endmodule
